/* File: bench/motor_model.sv */
// far-side model: speed feedback of the motor behind the main contactor
`timescale 1ns/10ps
module motor_model (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               contactorOn,
  input  wire logic signed [15:0] speedSet,
  output logic signed [15:0]      speedFb
);
  // dropped contactor: shaft taken as at rest, no coasting time modelled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      speedFb <= 16'sh0000;
    end else begin
      speedFb <= contactorOn ? speedSet : 16'sh0000;
    end
  end
endmodule

/* File: bench/speed_loop_chk.sv */
// port checker for the speed loop and stop sequencer
`timescale 1ns/10ps
module speed_loop_chk
  import speed_loop_pkg::*;
#(
  parameter int unsigned TRIP_CYCLES = TRIP_CYC
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire drive_pins_t        pinsIn,
  input wire logic               controlTick,
  input wire speed_in_t          speedIn,
  input wire logic               contactorOn,
  input wire logic               loopsInhibit,
  input wire logic signed [15:0] currentRef,
  input wire logic signed [15:0] thirdRefMonitor,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o
);
  int   faultCnt_r;
  logic enableReq;
  assign enableReq = pinsIn.ready && pinsIn.contactorStop && (pinsIn.start || pinsIn.jog);
  // consecutive cycles of lost ready or stop input, saturating to stay small
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultCnt_r <= 0;
    end else if (pinsIn.ready && pinsIn.contactorStop) begin
      faultCnt_r <= 0;
    end else if (faultCnt_r < int'(TRIP_CYCLES) + 8) begin
      faultCnt_r <= faultCnt_r + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_all_dropped;
    (!pinsIn.run && !pinsIn.start && !pinsIn.jog) [*6];
  endsequence
  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_energise_cond: assert property ($rose(contactorOn) |-> $past(enableReq, 3))
    else $error("contactor energised without enable");
  a_run_lost_drop: assert property (s_all_dropped |-> !contactorOn)
    else $error("contactor held after run lost");
  a_trip_drop: assert property (faultCnt_r > int'(TRIP_CYCLES) + 4 |-> !contactorOn)
    else $error("contactor held after ready or stop lost");
  a_inhibit_norun: assert property (!pinsIn.run [*4] |-> loopsInhibit)
    else $error("loops live with run low");
  a_ref_tick: assert property ($changed(currentRef) |-> $past(controlTick) || loopsInhibit)
    else $error("current reference moved off tick");
  a_monitor_ref3: assert property (!$past(rst) |-> thirdRefMonitor == $past(speedIn.ref3))
    else $error("third reference monitor wrong");
  a_bus_ack: assert property (s_bus_req |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
endmodule
bind speed_loop_stop_sequencer speed_loop_chk #(.TRIP_CYCLES(TRIP_CYCLES)) chk (
  .core_clk(core_clk), .rst(rst), .pinsIn(pinsIn), .controlTick(controlTick),
  .speedIn(speedIn), .contactorOn(contactorOn), .loopsInhibit(loopsInhibit),
  .currentRef(currentRef), .thirdRefMonitor(thirdRefMonitor), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

/* File: bench/testbench.sv */
// self-checking bench for the speed loop and stop sequencer
`timescale 1ns/10ps
module testbench;
  import speed_loop_pkg::*;
  localparam int unsigned TRIP = 20;
  localparam logic signed [15:0] ERRS [4] = '{16'sd50, 16'sd150, -16'sd150, 16'sd300};
  localparam logic signed [15:0] EXPS [4] = '{16'sd250, 16'sd1500, -16'sd1500, 16'sd4500};
  logic               core_clk, rst, controlTick, wbReq, wbWe, wbAck, contactorOn, loopsInhibit;
  logic signed [15:0] r1, r2, r3, r4, speedSet, speedFb, currentRef, speedDemand, thirdMon;
  logic [5:0]         wbAdr;
  logic [31:0]        wbDatW, wbDatR, rd;
  drive_pins_t        pins;
  speed_in_t          speedIn;
  int                 n_mismatch, checked, tickCnt;
  assign speedIn = '{r1, r2, r3, r4, speedFb};
  speed_loop_stop_sequencer #(.TRIP_CYCLES(TRIP)) dut (.core_clk(core_clk), .rst(rst),
    .pinsIn(pins), .controlTick(controlTick), .speedIn(speedIn), .contactorOn(contactorOn),
    .loopsInhibit(loopsInhibit), .currentRef(currentRef), .speedDemand(speedDemand),
    .thirdRefMonitor(thirdMon), .wb_cyc_i(wbReq), .wb_stb_i(wbReq), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck));
  motor_model motor (.core_clk(core_clk), .rst(rst), .contactorOn(contactorOn),
    .speedSet(speedSet), .speedFb(speedFb));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // control tick every eight clocks keeps stop sequences short
  always @(posedge core_clk) begin
    tickCnt <= (tickCnt == 7) ? 0 : tickCnt + 1;
    controlTick <= (tickCnt == 7);
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] ix, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    wbReq <= 1'b1;
    wbWe <= we;
    wbAdr <= {ix, 2'b00};
    wbDatW <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatR;
    wbReq <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic rdchk(input logic [3:0] ix, input logic [31:0] exp);
    wb(1'b0, ix, 16'h0000);
    chk(rd, exp);
  endtask
  task automatic pinsSet(input logic [5:0] v);
    @(posedge core_clk);
    pins <= drive_pins_t'(v);
    repeat (6) @(posedge core_clk);
  endtask
  task automatic waitTicks(input int k);
    repeat (k * 8) @(posedge core_clk);
  endtask
  // ------------------------------------------------------------
  // main sequence; pins are start,jog,run,stop input,ready,ramping
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {wbReq, wbWe, wbAdr, wbDatW, n_mismatch, checked} = '0;
    {r1, r2, r3, r4, speedSet} = '0;
    pins = '0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(IX_LO_KNEE, 32'h00000064);
    rdchk(IX_HI_KNEE, 32'h000000c8);
    rdchk(IX_LO_KP, 32'h000001f4);
    rdchk(IX_LO_TI, 32'h000003e8);
    rdchk(IX_RAMP_PCT, 32'h00002710);
    wb(1'b1, IX_STATUS, 16'hffff);
    rdchk(IX_STATUS, 32'h00000010);
    wb(1'b1, IX_TI, 16'h7530);
    wb(1'b1, IX_LO_TI, 16'h7530);
    wb(1'b1, IX_DROP_DLY, 16'h0003);
    pinsSet(6'b101000);
    chk(contactorOn, 1'b0);
    pinsSet(6'b101110);
    chk(contactorOn, 1'b1);
    // clamp of the summed references, both ways
    r1 <= 16'sd6000;
    r2 <= 16'sd6000;
    repeat (4) @(posedge core_clk);
    chk(speedDemand, 16'sd10000);
    wb(1'b1, IX_MAX_NEG, 16'h0bb8);
    r1 <= -16'sd6000;
    r2 <= -16'sd6000;
    repeat (4) @(posedge core_clk);
    chk(speedDemand, -16'sd3000);
    rdchk(IX_DEMAND, 32'hfffff448);
    wb(1'b1, IX_MAX_NEG, 16'h2710);
    wb(1'b1, IX_RATIO3, 16'h0000);
    r1 <= 16'sd1000;
    r2 <= 16'sd0;
    r3 <= 16'sd5000;
    repeat (4) @(posedge core_clk);
    chk(speedDemand, 16'sd1000);
    chk(thirdMon, 16'sd5000);
    // run low while running inhibits the loops and empties the integrator
    pinsSet(6'b100110);
    chk(loopsInhibit, 1'b1);
    chk(currentRef, 16'sd0);
    pinsSet(6'b101110);
    // long integral time: current reference is the proportional term alone
    r1 <= 16'sd100;
    waitTicks(2);
    chk(currentRef, 16'sd1500);
    wb(1'b1, IX_CTRL, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      r1 <= ERRS[i];
      waitTicks(2);
      chk(currentRef, EXPS[i]);
    end
    wb(1'b1, IX_CTRL, 16'h0004);
    r3 <= 16'sd1234;
    waitTicks(2);
    chk(currentRef, 16'sd1234);
    wb(1'b1, IX_CTRL, 16'h0000);
    // stop above drop-out speed: ramp down, timer not yet started
    r1 <= 16'sd100;
    speedSet <= 16'sd500;
    pinsSet(6'b001110);
    waitTicks(2);
    chk(speedDemand < 16'sd100 && speedDemand > 16'sd50, 1'b1);
    waitTicks(10);
    chk(speedDemand, 16'sd0);
    chk(contactorOn, 1'b1);
    speedSet <= 16'sd100;
    waitTicks(1);
    wb(1'b0, IX_STATUS, 16'h0000);
    chk(rd[1:0], 2'd3);
    chk(loopsInhibit, 1'b1);
    wb(1'b1, IX_CTRL, 16'h0002);
    chk(loopsInhibit, 1'b1);
    pinsSet(6'b011110);
    wb(1'b0, IX_STATUS, 16'h0000);
    chk(rd[1:0], 2'd1);
    pinsSet(6'b001110);
    waitTicks(2);
    chk(contactorOn, 1'b1);
    chk(loopsInhibit, 1'b0);
    waitTicks(4);
    chk(contactorOn, 1'b0);
    // run lost during a stop drops at once
    speedSet <= 16'sd500;
    pinsSet(6'b101110);
    pinsSet(6'b001110);
    chk(contactorOn, 1'b1);
    pinsSet(6'b000110);
    chk(contactorOn, 1'b0);
    // full-scale threshold: timer starts even beyond full reverse speed
    wb(1'b1, IX_DROP_SPD, 16'h2710);
    speedSet <= -16'sd20000;
    pinsSet(6'b101110);
    pinsSet(6'b001110);
    wb(1'b0, IX_STATUS, 16'h0000);
    chk(rd[1:0], 2'd3);
    pinsSet(6'b101110);
    pinsSet(6'b101100);
    chk(contactorOn, 1'b1);
    repeat (TRIP) @(posedge core_clk);
    chk(contactorOn, 1'b0);
    test_done();
  end
endmodule

/* File: inc/speed_loop_pkg.sv */
// constants, register map and carrier types for the speed loop and stop sequencer
package speed_loop_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned TRIP_MS    = 100;     // drop-out after lost ready or stop
  localparam int unsigned TRIP_CYC   = CLK_HZ / 1000 * TRIP_MS;
  localparam int          TICK_US    = 1000;    // control tick period
  localparam int          US_PER_MS  = 1000;

  // ---------------------------------------------------------------
  // scaling: percent in 0.01 % steps, gains in 0.01, times in ms
  // ---------------------------------------------------------------
  localparam logic [15:0] FULL_SCALE = 16'h2710;  // 100.00 %
  localparam int          PCT_DIV    = 10000;
  localparam int          GAIN_DIV   = 100;
  localparam int          S16_MAX    = 32767;
  localparam int          S16_MIN    = -32768;

  // ---------------------------------------------------------------
  // register map, word index; byte address is four times it
  // ---------------------------------------------------------------
  localparam int          NCFG       = 14;
  localparam logic [3:0]  IX_CTRL    = 4'h0;
  localparam logic [3:0]  IX_LO_KNEE = 4'h1;
  localparam logic [3:0]  IX_HI_KNEE = 4'h2;
  localparam logic [3:0]  IX_LO_KP   = 4'h3;
  localparam logic [3:0]  IX_LO_TI   = 4'h4;
  localparam logic [3:0]  IX_KP      = 4'h5;
  localparam logic [3:0]  IX_TI      = 4'h6;
  localparam logic [3:0]  IX_RAMP_PCT= 4'h7;
  localparam logic [3:0]  IX_RATIO3  = 4'h8;
  localparam logic [3:0]  IX_MAX_POS = 4'h9;
  localparam logic [3:0]  IX_MAX_NEG = 4'ha;
  localparam logic [3:0]  IX_STOP_RT = 4'hb;
  localparam logic [3:0]  IX_DROP_SPD= 4'hc;
  localparam logic [3:0]  IX_DROP_DLY= 4'hd;
  localparam logic [3:0]  IX_STATUS  = 4'he;
  localparam logic [3:0]  IX_DEMAND  = 4'hf;

  // control register bits
  localparam int          CB_ADAPT   = 0;
  localparam int          CB_LIVE    = 1;
  localparam int          CB_BYPASS  = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  localparam logic [15:0] RST_LO_KNEE= 16'h0064;  // 1.00 %
  localparam logic [15:0] RST_HI_KNEE= 16'h00c8;  // 2.00 %
  localparam logic [15:0] RST_LO_KP  = 16'h01f4;  // 5.00
  localparam logic [15:0] RST_LO_TI  = 16'h03e8;  // 1.000 s
  localparam logic [15:0] RST_KP     = 16'h05dc;  // 15.00
  localparam logic [15:0] RST_TI     = 16'h03e8;  // 1.000 s
  localparam logic [15:0] RST_RAMP   = 16'h2710;  // 100.00 %
  localparam logic [15:0] RST_RATIO3 = 16'h2710;  // 1.0000
  localparam logic [15:0] RST_MAXPOS = 16'h2710;
  localparam logic [15:0] RST_MAXNEG = 16'h2710;
  localparam logic [15:0] RST_STOPRT = 16'h000a;  // per tick
  localparam logic [15:0] RST_DRPSPD = 16'h00c8;
  localparam logic [15:0] RST_DRPDLY = 16'h03e8;  // ticks
  localparam logic [NCFG-1:0][15:0] CFG_RST = {
    RST_DRPDLY, RST_DRPSPD, RST_STOPRT, RST_MAXNEG, RST_MAXPOS, RST_RATIO3, RST_RAMP,
    RST_TI, RST_KP, RST_LO_TI, RST_LO_KP, RST_HI_KNEE, RST_LO_KNEE, RST_CTRL};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP, ST_DELAY} seq_t;

  typedef struct packed {
    logic start;
    logic jog;
    logic run;
    logic contactorStop;   // contactor_stop_input
    logic ready;
    logic ramping;
  } drive_pins_t;

  typedef struct packed {
    logic signed [15:0] ref1;
    logic signed [15:0] ref2;
    logic signed [15:0] ref3;
    logic signed [15:0] ref4;
    logic signed [15:0] speedFb;
  } speed_in_t;

endpackage

/* File: rtl/speed_loop_stop_sequencer.sv */
// speed reference summer, stop sequencer and adaptive speed PI with wishbone registers
//
// Function
// (R1) start or jog during delay restarts, timer zeroed
// (R2) delay timer starts at drop-out speed
// (R3) full-scale threshold starts timer on stop
// (R4) run low during stop drops contactor
// (R5) loops inhibited during delay unless live
// (R6) live mode latched at delay start
// (R7) sum references then clamp both ways
// (R8) stop ramps demand to zero, releases
// (R9) error equals demand minus feedback, PI
// (R10) bypass selects reference three as output
// (R11) zero ratio removes reference three from sum
// (R12) low gains below, normal above knees
// (R13) linear interpolation on error magnitude
// (R14) lower knee settable, default one percent
// (R15) upper knee settable, default two percent
// (R16) lower knee gain programmable, default five
// (R17) lower knee time programmable, default 1s
// (R18) ramping flag scales integral by percentage
// (R19) energise on ready, stop input, start/jog
// (R20) drop contactor 100 ms after fault
// (R21) delay expiry with no start drops contactor
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
module speed_loop_stop_sequencer
  import speed_loop_pkg::*;
#(
  parameter int unsigned TRIP_CYCLES = TRIP_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire drive_pins_t        pinsIn,
  input  wire logic               controlTick,
  input  wire speed_in_t          speedIn,
  output logic                    contactorOn,
  output logic                    loopsInhibit,
  output logic signed [15:0]      currentRef,
  output logic signed [15:0]      speedDemand,
  output logic signed [15:0]      thirdRefMonitor,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [5:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // all state in one struct: config words, sync
  // stages, sequencer, timers, loop and bus answer;
  // a field the comb block leaves alone keeps its
  // value, so only the changes are written there
  // and the flop block stays a plain copy
  typedef struct packed {
    logic [NCFG-1:0][15:0] cfg;
    drive_pins_t           sync1;
    drive_pins_t           sync2;
    seq_t                  seq;
    logic                  contactor;
    logic                  inhibit;
    logic                  liveLat;
    logic [15:0]           delayCnt;
    logic [31:0]           tripCnt;
    logic signed [15:0]    demand;
    logic signed [31:0]    integ;
    logic signed [15:0]    curRef;
    logic signed [15:0]    ref3Mon;
    logic                  ack;
    logic [31:0]           dat;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // saturate a 32-bit value into signed 16 bits
  // results clip here instead of wrapping
  function automatic logic signed [15:0] sat16(input int v);
    if (v > S16_MAX) begin
      return 16'sh7fff;
    end
    if (v < S16_MIN) begin
      return 16'sh8000;
    end
    return 16'(v);
  endfunction

  // magnitude; thresholds act alike in both
  // directions and for both error signs
  function automatic int mag(input int v);
    if (v < 0) begin
      return -v;
    end
    return v;
  endfunction

  // gain term against error magnitude between the two knees
  // equal knees give a plain switch; the early
  // returns keep the division away from zero
  function automatic int interp(input int e, input int lo, input int hi,
                                input int kLo, input int kHi);
    if (e < lo) begin
      return kLo;  // R12
    end
    if (e >= hi) begin
      return kHi;  // R12
    end
    return kLo + (kHi - kLo) * (e - lo) / (hi - lo);  // R13
  endfunction

  // ---------------------------------------------------------------
  // combinational working values
  // ---------------------------------------------------------------
  // each is set at the top of the comb block
  drive_pins_t p;
  logic        go;
  logic        healthy;
  logic        access;
  int          sum;
  int          target;
  int          err;
  int          errMag;
  int          kp;
  int          ti;
  int          fbMag;
  int          dropSpd;
  longint      inc;
  int          prop;
  logic [15:0] wr;
  logic [3:0]  idx;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    q_nxt   = q_r;
    p       = q_r.sync2;
    go      = p.start | p.jog;
    healthy = p.ready & p.contactorStop;
    idx     = wb_adr_i[5:2];
    access  = wb_cyc_i & wb_stb_i & ~q_r.ack;
    wr      = 16'h0000;
    sum     = 0;
    target  = 0;
    err     = 0;
    errMag  = 0;
    kp      = 0;
    ti      = 0;
    fbMag   = 0;
    dropSpd = 0;
    inc     = 0;
    prop    = 0;

    // pin synchronisers, second stage feeds all logic
    // first stage may go metastable; only the
    // second stage reads it
    q_nxt.sync1 = pinsIn;
    q_nxt.sync2 = q_r.sync1;

    // register bus: one wait state, ack dropped after one cycle
    // taken only while ack is low, so held cyc
    // and stb give one access per two cycles;
    // status and demand are read only
    q_nxt.ack = access;
    if (access) begin
      q_nxt.dat = 32'h0000_0000;
      if (wb_we_i) begin
        if (int'(idx) < NCFG) begin
          wr = q_r.cfg[idx];
          if (wb_sel_i[0]) begin
            wr[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            wr[15:8] = wb_dat_i[15:8];
          end
          q_nxt.cfg[idx] = wr;  // R14 R15 R16 R17
        end
      end else begin
        unique case (idx)
          IX_STATUS: q_nxt.dat = {26'h0, q_r.liveLat, q_r.inhibit, q_r.contactor,
                                  1'b0, q_r.seq};
          IX_DEMAND: q_nxt.dat = {{16{q_r.demand[15]}}, q_r.demand};
          default:   q_nxt.dat = {16'h0000, q_r.cfg[idx]};
        endcase
      end
    end

    // summed and clamped speed reference; zero ratio drops ref3
    // ratio in 0.01 % steps, full scale is unity;
    // negative limit held as a magnitude
    sum = int'(speedIn.ref1) + int'(speedIn.ref2) + int'(speedIn.ref4)
        + int'(speedIn.ref3) * int'(q_r.cfg[IX_RATIO3]) / PCT_DIV;  // R7 R11
    target = sum;
    if (target > int'(q_r.cfg[IX_MAX_POS])) begin
      target = int'(q_r.cfg[IX_MAX_POS]);  // R7
    end
    if (target < -int'(q_r.cfg[IX_MAX_NEG])) begin
      target = -int'(q_r.cfg[IX_MAX_NEG]);  // R7
    end
    // the monitor sees ref3 whatever the ratio
    q_nxt.ref3Mon = speedIn.ref3;  // R11

    // stop sequencer
    // idle: waits for a healthy start or jog
    // run: demand follows the reference
    // stop: ramp down; delay starts at drop-out speed
    // delay: ticks counted, restart zeroes it
    // run low in stop or delay opens at once
    fbMag   = mag(int'(speedIn.speedFb));  // R3
    dropSpd = int'(q_r.cfg[IX_DROP_SPD]);
    unique case (q_r.seq)
      ST_IDLE: begin
        // both health inputs and a start or jog
        if (healthy && go) begin
          q_nxt.seq = ST_RUN;  // R19
        end
      end
      ST_RUN: begin
        // start and jog both low begin the stop
        if (!go) begin
          q_nxt.seq = ST_STOP;
        end
      end
      ST_STOP: begin
        if (go) begin
          // stop ramp released as running resumes
          q_nxt.seq = ST_RUN;  // R8
        end else if (!p.run) begin
          q_nxt.seq = ST_IDLE;  // R4
        end else if (q_r.cfg[IX_DROP_SPD] >= FULL_SCALE || fbMag <= dropSpd) begin
          q_nxt.seq      = ST_DELAY;  // R2 R3
          q_nxt.delayCnt = 16'h0000;
          // sampled only here: a later write waits
          // for the next drop-out
          q_nxt.liveLat  = q_r.cfg[IX_CTRL][CB_LIVE];  // R6
        end
      end
      ST_DELAY: begin
        if (go) begin
          q_nxt.seq      = ST_RUN;  // R1
          // the next stop times its delay in full
          q_nxt.delayCnt = 16'h0000;  // R1
        end else if (!p.run) begin
          q_nxt.seq = ST_IDLE;  // R4
        end else if (controlTick) begin
          // count starts at zero, so the contactor
          // opens one tick after reaching the delay
          if (q_r.delayCnt >= q_r.cfg[IX_DROP_DLY]) begin
            q_nxt.seq = ST_IDLE;  // R21
          end else begin
            q_nxt.delayCnt = q_r.delayCnt + 16'h0001;  // R21
          end
        end
      end
    endcase

    // lost ready or stop input: contactor falls after the trip time
    // overrides every step above, restart too;
    // health back before the time clears the
    // count, so a short dip does no harm
    if (q_r.seq == ST_IDLE || healthy) begin
      q_nxt.tripCnt = 32'h0000_0000;
    end else if (q_r.tripCnt >= 32'(TRIP_CYCLES - 1)) begin
      q_nxt.seq     = ST_IDLE;  // R20
      q_nxt.tripCnt = 32'h0000_0000;
    end else begin
      q_nxt.tripCnt = q_r.tripCnt + 32'h0000_0001;  // R20
    end

    // taken from the next state: same edge as
    // the sequencer, three edges after the pins
    q_nxt.contactor = q_nxt.seq != ST_IDLE;  // R1 R19
    // loops rest while idle, not running, or in a dead delay
    // a latched live mode keeps them active
    q_nxt.inhibit = q_nxt.seq == ST_IDLE || !p.run
                  || (q_nxt.seq == ST_DELAY && !q_nxt.liveLat);  // R5

    // speed demand: follows the clamped reference, ramps down while stopping
    // one stop-rate step per tick, ends on zero;
    // a resumed run takes the reference at once
    if (q_r.seq == ST_RUN) begin
      q_nxt.demand = sat16(target);  // R8
    end else if (q_r.seq == ST_IDLE) begin
      q_nxt.demand = 16'sh0000;
    end else if (controlTick) begin
      if (int'(q_r.demand) > int'(q_r.cfg[IX_STOP_RT])) begin
        q_nxt.demand = sat16(int'(q_r.demand) - int'(q_r.cfg[IX_STOP_RT]));  // R8
      end else if (int'(q_r.demand) < -int'(q_r.cfg[IX_STOP_RT])) begin
        q_nxt.demand = sat16(int'(q_r.demand) + int'(q_r.cfg[IX_STOP_RT]));  // R8
      end else begin
        q_nxt.demand = 16'sh0000;  // R8
      end
    end

    // speed error and adaptive gain terms
    // gains in 0.01 steps, times in ms; the low
    // knee pair acts only with adaption on
    err    = int'(q_r.demand) - int'(speedIn.speedFb);  // R9
    errMag = mag(err);  // R13
    kp     = int'(q_r.cfg[IX_KP]);
    ti     = int'(q_r.cfg[IX_TI]);
    if (q_r.cfg[IX_CTRL][CB_ADAPT]) begin
      kp = interp(errMag, int'(q_r.cfg[IX_LO_KNEE]), int'(q_r.cfg[IX_HI_KNEE]),
                  int'(q_r.cfg[IX_LO_KP]), kp);  // R12 R13 R16
      ti = interp(errMag, int'(q_r.cfg[IX_LO_KNEE]), int'(q_r.cfg[IX_HI_KNEE]),
                  int'(q_r.cfg[IX_LO_TI]), ti);  // R12 R13 R17
    end
    if (ti < 1) begin
      ti = 1;  // a zero time would divide by zero
    end

    // integral step per tick: e * kp * tick / ti, scaled while ramping
    // 64-bit product avoids overflow; small
    // errors with long times round to no step,
    // a limit of the integer integrator
    inc = longint'(err) * longint'(kp) * longint'(TICK_US)
        / (longint'(GAIN_DIV) * longint'(US_PER_MS) * longint'(ti));  // R9
    // full scale leaves the step untouched
    if (p.ramping) begin
      inc = inc * longint'(q_r.cfg[IX_RAMP_PCT]) / longint'(PCT_DIV);  // R18
    end
    prop = err * kp / GAIN_DIV;  // R9

    // PI update on the control tick; cleared while inhibited
    // a restart after inhibit begins from rest,
    // not from a stale sum of the last run
    if (q_nxt.inhibit) begin
      q_nxt.integ  = 32'sh0000_0000;  // R5
      q_nxt.curRef = 16'sh0000;  // R5
    end else if (controlTick) begin
      q_nxt.integ = 32'(sat16(int'(q_r.integ) + int'(inc)));  // R9
      // bypass hands ref3 straight through
      if (q_r.cfg[IX_CTRL][CB_BYPASS]) begin
        q_nxt.curRef = speedIn.ref3;  // R10
      end else begin
        q_nxt.curRef = sat16(prop + int'(q_r.integ));  // R9
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset opens the contactor and inhibits
  // the loops without waiting for a clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_r          <= '0;
      q_r.cfg      <= CFG_RST;
      q_r.seq      <= ST_IDLE;
      q_r.inhibit  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from flops
  // no logic after the flops: no glitches,
  // and every output lags its cause by an edge
  assign contactorOn     = q_r.contactor;
  assign loopsInhibit    = q_r.inhibit;
  assign currentRef      = q_r.curRef;
  assign speedDemand     = q_r.demand;
  assign thirdRefMonitor = q_r.ref3Mon;
  assign wb_dat_o        = q_r.dat;
  assign wb_ack_o        = q_r.ack;

endmodule
